// File: rtl/rcal_pkg.sv
/*
 * constants, encodings and message text for the remote calibration and
 * serial control block.
 * assumes a 200 MHz system clock and a 2400 baud 8N1 serial link.
 */
package rcal_pkg;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_HZ           = 200_000_000;
  localparam int BAUD_RATE        = 2400;
  localparam int BIT_CYC_DEF      = CLK_HZ / BAUD_RATE;
  localparam int STATUS_PERIOD_MS = 2000;
  localparam int STATUS_CYC_DEF   = (CLK_HZ / 1000) * STATUS_PERIOD_MS;
  localparam int DATA_BITS        = 8;
  localparam int FIFO_DEPTH       = 16;

  // ***************************************************
  // ranges and calibration states
  // ***************************************************
  typedef enum logic [1:0] {
    RNG_ONE   = 2'h0,
    RNG_TWO   = 2'h1,
    RNG_THREE = 2'h2,
    RNG_CAL   = 2'h3
  } range_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'h0,
    CAL_ZERO = 2'h1,
    CAL_SPAN = 2'h2
  } cal_state_t;

  // range id dac codes, 12 bits full scale = 1.00 V / 20 mA
  localparam logic [11:0] RID_ONE   = 12'h400;
  localparam logic [11:0] RID_TWO   = 12'h800;
  localparam logic [11:0] RID_THREE = 12'hC00;
  localparam logic [11:0] RID_CAL   = 12'hFFF;

  // ***************************************************
  // characters and commands
  // ***************************************************
  localparam logic [7:0]  CHR_CR    = 8'h0D;
  localparam logic [7:0]  CHR_LF    = 8'h0A;
  localparam logic [7:0]  CHR_ZERO  = 8'h30;
  localparam logic [7:0]  CHR_ONE   = 8'h31;
  localparam logic [7:0]  CHR_FOUR  = 8'h34;
  localparam logic [15:0] CMD_ASPAN = 16'h6173;
  localparam logic [15:0] CMD_AZERO = 16'h617A;
  localparam logic [15:0] CMD_UNLK  = 16'h7270;
  localparam logic [15:0] CMD_STAT  = 16'h7374;
  localparam logic [15:0] CMD_RAUTO = 16'h7261;
  localparam logic [15:0] CMD_RMAN  = 16'h726D;

  // status lines, 14 bytes each except the 3-byte CAL text, zero bytes are skipped
  localparam logic [111:0] TXT_DIS1 = {"AL-1 DISABLED", 8'h00};
  localparam logic [111:0] TXT_DIS2 = {"AL-2 DISABLED", 8'h00};
  localparam logic [111:0] TXT_ON1  = {"AL-1 ON", 56'h0};
  localparam logic [111:0] TXT_ON2  = {"AL-2 ON", 56'h0};
  localparam logic [111:0] TXT_ONS  = {"AL-S ON", 56'h0};
  localparam logic [23:0]  TXT_CAL  = "CAL";

endpackage

// File: rtl/byte_fifo.sv
/*
 * synchronous fifo with valid/ready on both sides.
 * assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  logic             mclk,
  input  logic             rst_n,
  // fill side
  input  logic             in_valid,
  output logic             in_ready,
  input  logic [WIDTH-1:0] in_data,
  // drain side
  output logic             out_valid,
  input  logic             out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) wr_ff <= wr_ff + 1'b1;
      if (pop) rd_ff <= rd_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_no_overrun : assert property (@(posedge mclk) disable iff (!rst_n)
    cnt_ff <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
endmodule

// File: rtl/remote_cal_ctrl.sv
/*
 * remote calibration handshake, range id, alarm relays and serial status
 * reporting with a small command interpreter.
 * assumes remote cal inputs, the power switch and rxd come from pins;
 * concentration, thresholds, faults, keys and cal_done are on mclk.
 */
`timescale 1ns/10ps
module remote_cal_ctrl #(
  parameter int BIT_CYC    = rcal_pkg::BIT_CYC_DEF,
  parameter int STATUS_CYC = rcal_pkg::STATUS_CYC_DEF
) (
  // clock and reset
  input  logic        mclk,
  input  logic        rst_n,
  // remote calibration pins
  input  logic        rmt_zero,
  input  logic        rmt_span,
  output logic        cal_busy,
  output logic        cal_zero_active,
  output logic        cal_span_active,
  input  logic        cal_done,
  // measurement
  input  logic [15:0] conc_in,
  output logic [15:0] conc_out,
  input  logic [1:0]  auto_range,
  input  logic [15:0] range_scale,
  output logic [11:0] range_id_code,
  output logic [3:0]  range_relay,
  // threshold alarms
  input  logic [15:0] alm_thresh_one,
  input  logic [15:0] alm_thresh_two,
  input  logic [1:0]  alm_high,
  input  logic [1:0]  alm_failsafe,
  input  logic [1:0]  alm_latch,
  input  logic [1:0]  alm_defeat,
  input  logic        alm_reset,
  output logic [1:0]  alm_relay,
  // system alarm
  input  logic        power_fault,
  input  logic        zero_balance_fail,
  input  logic        span_limit_fail,
  input  logic        selftest_fail,
  input  logic        power_sw_off,
  input  logic        key_press,
  input  logic        key_is_system,
  output logic        sys_alarm,
  output logic        sys_relay,
  // serial port and mode flags
  input  logic        rxd,
  output logic        txd,
  output logic        status_enable,
  output logic        reprogram_unlock
);

  // ***************************************************
  // pin synchronisers
  // ***************************************************
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      // idle pin levels: a high reset value would fake a cal request
      meta_ff <= 4'h8;
      sync_ff <= 4'h8;
    end else begin
      meta_ff <= {rxd, power_sw_off, rmt_span, rmt_zero};
      sync_ff <= meta_ff;
    end
  end
  logic rz_s, rs_s, sw_off_s, rxd_s;
  assign rz_s     = sync_ff[0] && rst_n;
  assign rs_s     = sync_ff[1] && rst_n;
  assign sw_off_s = sync_ff[2];
  assign rxd_s    = sync_ff[3];

  // ***************************************************
  // calibration handshake
  // ***************************************************
  rcal_pkg::cal_state_t state_ff;
  logic cmd_azero, cmd_aspan;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_ff <= rcal_pkg::CAL_IDLE;
    end else begin
      unique case (state_ff)
        rcal_pkg::CAL_IDLE: begin
          // idle polls pins every cycle, nothing is latched while busy
          if (rz_s || cmd_azero) state_ff <= rcal_pkg::CAL_ZERO;
          else if (rs_s || cmd_aspan) state_ff <= rcal_pkg::CAL_SPAN;
        end
        // one idle cycle on completion reopens the contact; a held
        // request then closes it again
        rcal_pkg::CAL_ZERO, rcal_pkg::CAL_SPAN: begin
          if (cal_done) state_ff <= rcal_pkg::CAL_IDLE;
        end
        default: state_ff <= rcal_pkg::CAL_IDLE;
      endcase
    end
  end
  assign cal_zero_active = (state_ff == rcal_pkg::CAL_ZERO);
  assign cal_span_active = (state_ff == rcal_pkg::CAL_SPAN);
  assign cal_busy        = cal_zero_active || cal_span_active;

  // sample and hold of concentration
  logic [15:0] conc_ff;
  always_ff @(posedge mclk) begin
    if (!rst_n) conc_ff <= '0;
    else if (state_ff == rcal_pkg::CAL_IDLE && !cmd_azero && !cmd_aspan
             && !rz_s && !rs_s) conc_ff <= conc_in;
  end
  assign conc_out = conc_ff;

  a_zero_start : assert property (@(posedge mclk) disable iff (!rst_n)
    (state_ff == rcal_pkg::CAL_IDLE && rz_s) |=> cal_zero_active)
    else $error("zero request did not start zero cal");
  a_busy_contact : assert property (@(posedge mclk) disable iff (!rst_n)
    cal_busy |-> (cal_zero_active ^ cal_span_active))
    else $error("busy contact without exactly one cal mode");
  a_no_queue : assert property (@(posedge mclk) disable iff (!rst_n)
    (cal_busy && !cal_done) |=> (state_ff == $past(state_ff)))
    else $error("request acted on during calibration");
  a_repeat_cal : assert property (@(posedge mclk) disable iff (!rst_n)
    (cal_zero_active && cal_done ##1 rz_s) |=> cal_zero_active)
    else $error("held zero request did not repeat cal");
  a_hold_value : assert property (@(posedge mclk) disable iff (!rst_n)
    (cal_busy && $past(cal_busy)) |-> $stable(conc_out))
    else $error("concentration moved during calibration");

  // ***************************************************
  // range selection and range id
  // ***************************************************
  logic            manual_ff;
  rcal_pkg::range_t man_rng_ff;
  rcal_pkg::range_t rng;
  always_comb begin
    if (cal_busy) rng = rcal_pkg::RNG_CAL;
    else if (manual_ff) rng = man_rng_ff;
    else if (auto_range == 2'h3) rng = rcal_pkg::RNG_THREE;
    else rng = rcal_pkg::range_t'(auto_range);
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      range_id_code <= rcal_pkg::RID_ONE;
      range_relay   <= 4'h1;
    end else begin
      range_relay <= 4'h1 << rng;
      unique case (rng)
        rcal_pkg::RNG_ONE:   range_id_code <= rcal_pkg::RID_ONE;
        rcal_pkg::RNG_TWO:   range_id_code <= rcal_pkg::RID_TWO;
        rcal_pkg::RNG_THREE: range_id_code <= rcal_pkg::RID_THREE;
        rcal_pkg::RNG_CAL:   range_id_code <= rcal_pkg::RID_CAL;
      endcase
    end
  end
  a_cal_range_id : assert property (@(posedge mclk) disable iff (!rst_n)
    $past(cal_busy) && $past(rst_n) |-> (range_id_code == rcal_pkg::RID_CAL
    && range_relay == 4'h8)) else $error("cal range id not shown");

  // ***************************************************
  // threshold alarms
  // ***************************************************
  logic [1:0] alm_on_ff;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_alm
      logic [15:0] th;
      logic        cond;
      assign th   = (gi == 0) ? alm_thresh_one : alm_thresh_two;
      assign cond = alm_high[gi] ? (conc_ff > th) : (conc_ff < th);
      always_ff @(posedge mclk) begin
        if (!rst_n) alm_on_ff[gi] <= 1'b0;
        else if (alm_defeat[gi]) alm_on_ff[gi] <= 1'b0;
        else if (cond) alm_on_ff[gi] <= 1'b1;
        else if (!alm_latch[gi] || alm_reset) alm_on_ff[gi] <= 1'b0;
      end
      // fail-safe relays sit energized while healthy
      assign alm_relay[gi] = alm_on_ff[gi] ^ alm_failsafe[gi];
    end
  endgenerate
  a_defeat_quiet : assert property (@(posedge mclk) disable iff (!rst_n)
    $past(alm_defeat[0]) |-> !alm_on_ff[0])
    else $error("defeated alarm asserted");

  // ***************************************************
  // system alarm
  // ***************************************************
  logic sys_ff, sw_seen_ff, sys_fault, sys_clr;
  assign sys_fault = power_fault || zero_balance_fail || span_limit_fail
                     || selftest_fail;
  assign sys_clr   = sw_seen_ff && !sw_off_s && key_press && !key_is_system;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sys_ff     <= 1'b0;
      sw_seen_ff <= 1'b0;
    end else begin
      // a fault in the clearing cycle wins over the clear
      if (sys_fault) sys_ff <= 1'b1;
      else if (sys_clr) sys_ff <= 1'b0;
      if (!sys_ff || sys_clr) sw_seen_ff <= 1'b0;
      else if (sw_off_s) sw_seen_ff <= 1'b1;
    end
  end
  assign sys_alarm = sys_ff;
  assign sys_relay = !sys_ff;
  a_sys_latch : assert property (@(posedge mclk) disable iff (!rst_n)
    (sys_ff && !sys_clr) |=> sys_ff) else $error("system alarm unlatched");
  a_sys_set : assert property (@(posedge mclk) disable iff (!rst_n)
    power_fault |=> (sys_alarm && !sys_relay))
    else $error("power fault missed");

  // ***************************************************
  // serial receiver
  // ***************************************************
  logic        rx_busy_ff;
  logic [16:0] rx_cnt_ff;
  logic [3:0]  rx_bit_ff;
  logic [7:0]  rx_sh_ff;
  logic        rx_vld_ff;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx_busy_ff <= 1'b0;
      rx_cnt_ff  <= '0;
      rx_bit_ff  <= '0;
      rx_sh_ff   <= '0;
      rx_vld_ff  <= 1'b0;
    end else begin
      rx_vld_ff <= 1'b0;
      if (!rx_busy_ff) begin
        if (!rxd_s) begin
          rx_busy_ff <= 1'b1;
          rx_cnt_ff  <= 17'(BIT_CYC / 2); // sample mid-bit
          rx_bit_ff  <= '0;
        end
      end else if (rx_cnt_ff != '0) begin
        rx_cnt_ff <= rx_cnt_ff - 1'b1;
      end else begin
        rx_cnt_ff <= 17'(BIT_CYC - 1);
        rx_bit_ff <= rx_bit_ff + 1'b1;
        if (rx_bit_ff == 4'h0 && rxd_s) rx_busy_ff <= 1'b0; // glitch
        else if (rx_bit_ff == 4'h9) begin
          rx_busy_ff <= 1'b0;
          rx_vld_ff  <= rxd_s; // frame with bad stop bit is dropped
        end else if (rx_bit_ff != 4'h0) rx_sh_ff <= {rxd_s, rx_sh_ff[7:1]};
      end
    end
  end

  // ***************************************************
  // command interpreter
  // ***************************************************
  logic [23:0] buf_ff;
  logic [1:0]  len_ff;
  logic        ovf_ff;
  logic        at_cr, hit2, hit3, cmd_stat, cmd_unlk, cmd_rauto;
  assign at_cr     = rx_vld_ff && rx_sh_ff == rcal_pkg::CHR_CR && !ovf_ff;
  assign hit2      = at_cr && len_ff == 2'h2;
  assign hit3      = at_cr && len_ff == 2'h3 &&
                     buf_ff[23:8] == rcal_pkg::CMD_RMAN &&
                     buf_ff[7:0] >= rcal_pkg::CHR_ONE &&
                     buf_ff[7:0] <= rcal_pkg::CHR_FOUR;
  assign cmd_azero = hit2 && buf_ff[15:0] == rcal_pkg::CMD_AZERO;
  assign cmd_aspan = hit2 && buf_ff[15:0] == rcal_pkg::CMD_ASPAN;
  assign cmd_stat  = hit2 && buf_ff[15:0] == rcal_pkg::CMD_STAT;
  assign cmd_unlk  = hit2 && buf_ff[15:0] == rcal_pkg::CMD_UNLK;
  assign cmd_rauto = hit2 && buf_ff[15:0] == rcal_pkg::CMD_RAUTO;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      buf_ff <= '0;
      len_ff <= '0;
      ovf_ff <= 1'b0;
    end else if (rx_vld_ff) begin
      if (rx_sh_ff == rcal_pkg::CHR_CR) begin
        len_ff <= '0;
        ovf_ff <= 1'b0;
      end else if (rx_sh_ff == rcal_pkg::CHR_LF) begin
        // a terminal's trailing lf must not poison the next command
      end else if (len_ff == 2'h3) ovf_ff <= 1'b1;
      else begin
        buf_ff <= {buf_ff[15:0], rx_sh_ff};
        len_ff <= len_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_enable    <= 1'b1;
      reprogram_unlock <= 1'b0;
      manual_ff        <= 1'b0;
      man_rng_ff       <= rcal_pkg::RNG_ONE;
    end else begin
      if (cmd_stat) status_enable <= !status_enable;
      if (cmd_unlk) reprogram_unlock <= 1'b1;
      if (cmd_rauto) manual_ff <= 1'b0;
      else if (hit3) begin
        manual_ff  <= 1'b1;
        man_rng_ff <= rcal_pkg::range_t'(buf_ff[1:0] - 2'h1);
      end
    end
  end
  a_stat_toggle : assert property (@(posedge mclk) disable iff (!rst_n)
    cmd_stat |=> (status_enable != $past(status_enable)))
    else $error("status toggle ignored");

  // ***************************************************
  // status report generator
  // ***************************************************
  function automatic logic [7:0] hex_chr(input logic [3:0] n);
    hex_chr = (n < 4'hA) ? 8'(rcal_pkg::CHR_ZERO + 8'(n)) : 8'(8'h37 + 8'(n));
  endfunction
  function automatic logic [7:0] txt_chr(input logic [111:0] s,
                                         input logic [3:0]   p);
    txt_chr = s[8*(13-int'(p)) +: 8];
  endfunction
  function automatic logic [7:0] cal_chr(input logic [3:0] p);
    cal_chr = rcal_pkg::TXT_CAL[8*(2-int'(p)) +: 8];
  endfunction

  logic [28:0] per_ff;
  logic        gen_ff;
  logic [6:0]  slot_ff;
  logic [2:0]  item;
  logic [3:0]  pos;
  logic        item_on;
  logic [7:0]  ch;
  logic        f_ready, f_valid, tx_take;
  logic [7:0]  f_data;
  assign item = slot_ff[6:4];
  assign pos  = slot_ff[3:0];

  always_comb begin
    unique case (item)
      3'h3: item_on = alm_defeat[0];
      3'h4: item_on = alm_defeat[1];
      3'h5: item_on = alm_on_ff[0];
      3'h6: item_on = alm_on_ff[1];
      3'h7: item_on = sys_ff;
      default: item_on = 1'b1;
    endcase
    ch = 8'h00;
    if (!item_on) ch = 8'h00;
    else if (pos == 4'hE) ch = rcal_pkg::CHR_CR;
    else if (pos == 4'hF) ch = rcal_pkg::CHR_LF;
    else begin
      unique case (item)
        3'h0: if (pos < 4'h4) ch = hex_chr(conc_ff[4'(4'hC - 4*pos) +: 4]);
        3'h1: begin
          if (rng == rcal_pkg::RNG_CAL) begin
            if (pos < 4'h3) ch = cal_chr(pos);
          end else if (pos == 4'h0) ch = rcal_pkg::CHR_ZERO;
          else if (pos == 4'h1) ch = 8'(rcal_pkg::CHR_ONE + 8'(rng));
        end
        3'h2: if (pos < 4'h4) ch = hex_chr(range_scale[4'(4'hC - 4*pos) +: 4]);
        3'h3: ch = txt_chr(rcal_pkg::TXT_DIS1, pos);
        3'h4: ch = txt_chr(rcal_pkg::TXT_DIS2, pos);
        3'h5: ch = txt_chr(rcal_pkg::TXT_ON1, pos);
        3'h6: ch = txt_chr(rcal_pkg::TXT_ON2, pos);
        3'h7: ch = txt_chr(rcal_pkg::TXT_ONS, pos);
      endcase
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) per_ff <= '0;
    else if (per_ff == 29'(STATUS_CYC - 1)) per_ff <= '0;
    else per_ff <= per_ff + 1'b1;
  end

  // a report still draining when the next tick arrives is not restarted
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      gen_ff  <= 1'b0;
      slot_ff <= '0;
    end else if (!gen_ff) begin
      if (per_ff == 29'(STATUS_CYC - 1) && status_enable) begin
        gen_ff  <= 1'b1;
        slot_ff <= '0;
      end
    end else if (ch == 8'h00 || f_ready) begin
      slot_ff <= slot_ff + 1'b1;
      if (slot_ff == 7'h7F) gen_ff <= 1'b0;
    end
  end
  a_line_end : assert property (@(posedge mclk) disable iff (!rst_n)
    (gen_ff && f_ready && ch == rcal_pkg::CHR_CR) |=> (ch == rcal_pkg::CHR_LF))
    else $error("line not closed with lf");

  byte_fifo #(
    .WIDTH (rcal_pkg::DATA_BITS),
    .DEPTH (rcal_pkg::FIFO_DEPTH)
  ) u_txq (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_valid  (gen_ff && ch != 8'h00),
    .in_ready  (f_ready),
    .in_data   (ch),
    .out_valid (f_valid),
    .out_ready (tx_take),
    .out_data  (f_data)
  );

  // ***************************************************
  // serial transmitter, 8n1
  // ***************************************************
  logic [9:0]  tx_sh_ff;
  logic [3:0]  tx_bit_ff;
  logic [16:0] tx_cnt_ff;
  logic        tx_busy_ff;
  assign tx_take = f_valid && !tx_busy_ff;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_sh_ff   <= 10'h3FF;
      tx_bit_ff  <= '0;
      tx_cnt_ff  <= '0;
      tx_busy_ff <= 1'b0;
      txd        <= 1'b1;
    end else if (tx_take) begin
      tx_sh_ff   <= {1'b1, f_data, 1'b0};
      tx_bit_ff  <= '0;
      tx_cnt_ff  <= 17'(BIT_CYC - 1);
      tx_busy_ff <= 1'b1;
      txd        <= 1'b0;
    end else if (tx_busy_ff) begin
      if (tx_cnt_ff != '0) tx_cnt_ff <= tx_cnt_ff - 1'b1;
      else if (tx_bit_ff == 4'h9) tx_busy_ff <= 1'b0;
      else begin
        tx_cnt_ff <= 17'(BIT_CYC - 1);
        tx_bit_ff <= tx_bit_ff + 1'b1;
        tx_sh_ff  <= {1'b1, tx_sh_ff[9:1]};
        txd       <= tx_sh_ff[1];
      end
    end
  end
  a_start_bit : assert property (@(posedge mclk) disable iff (!rst_n)
    tx_take |=> !txd [*2]) else $error("start bit too short");
endmodule

// File: test/serial_host.sv
/* serial terminal model: sends command bytes, decodes status bytes.
   assumes 8N1 framing at BIT_CYC clocks per bit, lines idle high. */
`timescale 1ns/10ps
module serial_host #(
  parameter int BIT_CYC = 8
) (
  // clock
  input  wire logic mclk,
  // serial lines
  output logic      rxd,
  input  wire logic txd
);
  logic [7:0] rx_last   = 8'h00;
  logic       crlf_seen = 1'b0;
  int         n_rx      = 0;
  initial rxd = 1'b1;
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge mclk);
    end
  endtask
  // sample mid-bit; a bad stop bit throws the byte away
  always begin
    logic [7:0] b;
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge mclk);
      b[i] = txd;
    end
    repeat (BIT_CYC) @(posedge mclk);
    if (txd === 1'b1) begin
      if (rx_last === 8'h0D && b === 8'h0A) crlf_seen = 1'b1;
      rx_last = b;
      n_rx++;
    end
  end
endmodule

// File: test/remote_cal_ctrl_tb.sv
/* testbench for remote_cal_ctrl with a serial terminal model.
   assumes short bit and report periods set through parameters. */
`timescale 1ns/10ps
module remote_cal_ctrl_tb;
  logic        mclk = 1'b0, rst_n = 1'b0, rxd, txd, cal_done = 1'b0;
  logic        rmt_zero = 1'b0, rmt_span = 1'b0, alm_reset = 1'b0;
  logic        power_sw_off = 1'b0, key_press = 1'b0, key_is_system = 1'b0;
  logic        cal_busy, cal_zero_active, cal_span_active, sys_alarm;
  logic        sys_relay, status_enable, reprogram_unlock;
  logic [15:0] conc_in = 16'h0000, conc_out, range_scale = 16'h1234, held;
  logic [15:0] alm_thresh_one = 16'hFFFF, alm_thresh_two = 16'h0000;
  logic [1:0]  auto_range = 2'h0, alm_high = 2'h3, alm_failsafe = 2'h0;
  logic [1:0]  alm_latch = 2'h0, alm_defeat = 2'h2, alm_relay;
  logic [11:0] range_id_code;
  logic [3:0]  range_relay, flt = 4'h0;
  int          fails = 0, n_compared = 0, seed = 32'h3DF332DB, k0;
  always #2.5 mclk = ~mclk;
  remote_cal_ctrl #(.BIT_CYC(8), .STATUS_CYC(8000)) u_remote_cal_ctrl (
    .mclk, .rst_n, .rmt_zero, .rmt_span, .cal_busy, .cal_zero_active,
    .cal_span_active, .cal_done, .conc_in, .conc_out, .auto_range,
    .range_scale, .range_id_code, .range_relay, .alm_thresh_one,
    .alm_thresh_two, .alm_high, .alm_failsafe, .alm_latch, .alm_defeat,
    .alm_reset, .alm_relay, .power_fault(flt[0]),
    .zero_balance_fail(flt[1]), .span_limit_fail(flt[2]),
    .selftest_fail(flt[3]), .power_sw_off, .key_press, .key_is_system,
    .sys_alarm, .sys_relay, .rxd, .txd, .status_enable, .reprogram_unlock);
  serial_host #(.BIT_CYC(8)) u_serial_host (.mclk, .rxd, .txd);
  function automatic logic [11:0] rid(input int r);
    return (r == 3) ? 12'hFFF : 12'(12'h400 * (r + 1));
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // bytes go out first char first, cr always closes the line
  task automatic cmd(input logic [23:0] s, input int n);
    for (int i = n - 1; i >= 0; i--) u_serial_host.send(s[i*8 +: 8]);
    u_serial_host.send(8'h0D);
    cyc(2);
  endtask
  task automatic done_pulse;
    cal_done = 1'b1;
    cyc(1);
    cal_done = 1'b0;
  endtask
  task automatic press(input logic s);
    key_is_system = s;
    key_press = 1'b1;
    cyc(1);
    key_press = 1'b0;
    cyc(3);
  endtask
  task automatic alm(input logic [1:0] h, f, l, input logic [15:0] t, e);
    alm_high = h;
    alm_failsafe = f;
    alm_latch = l;
    alm_thresh_one = t;
    cyc(5);
    chk("alm_relay", e, 16'(alm_relay));
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200_000;
    fails++;
    finish_test();
  end
  initial begin
    cyc(5);
    rst_n = 1'b1;
    conc_in = 16'h4000 | 16'($random(seed)) & 16'h3FFF;
    cyc(4);
    held = conc_in;
    // zero gas valve follows the zero command on the controller side
    rmt_zero = 1'b1;
    for (int k = 0; k < 20 && cal_busy !== 1'b1; k++) cyc(1);
    chk("zero_busy", 16'h3, 16'({cal_busy, cal_zero_active}));
    conc_in = ~held;
    rmt_span = 1'b1;
    cyc(6);
    chk("held", held, conc_out);
    chk("span", 16'h0, 16'(cal_span_active));
    rmt_span = 1'b0;
    done_pulse();
    chk("gap", 16'h0, 16'(cal_busy));
    cyc(1);
    chk("again", 16'h1, 16'(cal_busy));
    rmt_zero = 1'b0;
    // let the release pass the pin synchroniser before cal ends
    cyc(3);
    done_pulse();
    cyc(8);
    chk("idle", 16'h0, 16'(cal_busy));
    for (int r = 0; r < 4; r++) begin
      cmd({8'h72, 8'h6D, 8'h31 + 8'(r)}, 3);
      chk("rid", 16'(rid(r)), 16'(range_id_code));
      chk("rrel", 16'(1 << r), 16'(range_relay));
    end
    auto_range = 2'($unsigned($random(seed)) % 3);
    cmd({8'h00, 8'h72, 8'h61}, 2);
    chk("rauto", 16'(rid(auto_range)), 16'(range_id_code));
    cmd({8'h00, 8'h73, 8'h74}, 2);
    cmd({8'h00, 8'h71, 8'h71}, 2);
    chk("flags", 16'h0, 16'({status_enable, reprogram_unlock}));
    cmd({8'h00, 8'h73, 8'h74}, 2);
    cmd({8'h00, 8'h72, 8'h70}, 2);
    chk("flags", 16'h3, 16'({status_enable, reprogram_unlock}));
    cmd({8'h00, 8'h61, 8'h7A}, 2);
    chk("az", 16'h1, 16'(cal_zero_active));
    done_pulse();
    cmd({8'h00, 8'h61, 8'h73}, 2);
    chk("as", 16'h1, 16'(cal_span_active));
    done_pulse();
    alm(2'h3, 2'h0, 2'h0, 16'h3FFF, 16'h1);
    alm(2'h0, 2'h0, 2'h0, 16'h3FFF, 16'h0);
    alm(2'h0, 2'h0, 2'h0, 16'hFFFF, 16'h1);
    alm(2'h3, 2'h3, 2'h0, 16'h3FFF, 16'h2);
    alm(2'h3, 2'h0, 2'h0, 16'hFFFF, 16'h0);
    alm(2'h3, 2'h0, 2'h1, 16'h3FFF, 16'h1);
    alm(2'h3, 2'h0, 2'h1, 16'hFFFF, 16'h1);
    alm_reset = 1'b1;
    alm(2'h3, 2'h0, 2'h1, 16'hFFFF, 16'h0);
    for (int f = 0; f < 4; f++) begin
      flt = 4'(1 << f);
      cyc(3);
      flt = 4'h0;
      press(1'b0);
      chk("sys", 16'h2, 16'({sys_alarm, sys_relay}));
      power_sw_off = 1'b1;
      cyc(4);
      power_sw_off = 1'b0;
      press(1'b1);
      chk("syskey", 16'h1, 16'(sys_alarm));
      press(1'b0);
      chk("clr", 16'h1, 16'({sys_alarm, sys_relay}));
    end
    k0 = u_serial_host.n_rx;
    cyc(14000);
    chk("report", 16'h3, 16'({u_serial_host.n_rx > k0,
                              u_serial_host.crlf_seen}));
    finish_test();
  end
endmodule
